// ### logic/caf_defs.svh
// caf_defs.svh: offsets, field positions, reset values of the acceptance filter setup block
// assumes inclusion by bare name from logic/ files only
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH
`define CAF_OFS_GLOBAL 8'h80
`define CAF_OFS_STD 8'h84
`define CAF_OFS_EXT 8'h88
`define CAF_OFS_MASK 8'h90
`define CAF_OFS_CTRL 8'h18
`define CAF_NFS_HI 5
`define CAF_NFS_LO 4
`define CAF_NFE_HI 3
`define CAF_NFE_LO 2
`define CAF_RRS_BIT 1
`define CAF_RRE_BIT 0
`define CAF_LSS_HI 23
`define CAF_LSS_LO 16
`define CAF_LSE_HI 22
`define CAF_LSE_LO 16
`define CAF_SA_HI 15
`define CAF_SA_LO 2
`define CAF_MASK_HI 28
`define CAF_INIT_BIT 0
`define CAF_CCE_BIT 1
`define CAF_STD_MAX 8'h80
`define CAF_EXT_MAX 7'h40
`define CAF_MASK_RESET 29'h1fffffff
`define CAF_CTRL_RESET 2'h1
`endif

// ### logic/caf_pkg.sv
// caf_pkg: types shared by the acceptance filter setup block
// assumes caf_defs.svh is visible beside it
package caf_pkg;
    // where a frame that matched nothing is sent
    typedef enum logic [1:0] {
        CAF_TO_FIFO0,
        CAF_TO_FIFO1,
        CAF_DISCARD
    } caf_route_e;
    // bus slave phases
    typedef enum logic [1:0] {
        CAF_IDLE,
        CAF_RESP,
        CAF_DONE
    } caf_bus_e;
    typedef logic [15:0] caf_addr_t;
endpackage

// ### logic/caf_limit.sv
// caf_limit: clamps a programmed list size and forms the list byte address
// assumes a purely combinational use on the module clock
`timescale 1ns/100ps
`default_nettype none
module caf_limit #(
    parameter int W = 8,
    parameter logic [7:0] MAX = 8'h80
) (
    input wire logic [W-1:0] size_raw,
    input wire logic [13:0] word_addr,
    output logic [7:0] size_eff,
    output logic list_on,
    output caf_pkg::caf_addr_t byte_addr
);
    logic [7:0] raw8; // size widened for comparison
    assign raw8 = 8'(size_raw);
    // values above the maximum count as the maximum
    assign size_eff = (raw8 > MAX) ? MAX : raw8;
    // zero means the list is unused
    assign list_on = (raw8 != 8'h00);
    // word address shifted to bytes
    assign byte_addr = {word_addr, 2'b00};
endmodule
`default_nettype wire

// ### logic/caf_route.sv
// caf_route: decides the fate of a received frame that matched no element
// assumes inputs are stable flags from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module caf_route (
    input wire logic [1:0] action,
    input wire logic remote,
    input wire logic reject_remote,
    output caf_pkg::caf_route_e route,
    output logic bypass
);
    // remote frames may be dropped before any filtering
    assign bypass = remote & reject_remote;
    // both upper codes reject the frame
    always_comb begin
        unique case (action)
            2'b00: route = caf_pkg::CAF_TO_FIFO0;
            2'b01: route = caf_pkg::CAF_TO_FIFO1;
            default: route = caf_pkg::CAF_DISCARD;
        endcase
    end
endmodule
`default_nettype wire

// ### logic/caf_top.sv
// caf_top: acceptance filter configuration registers on an Avalon-MM slave
// assumes a single 125 MHz clock, the frame receiver on the same clock
`include "caf_defs.svh"
`timescale 1ns/100ps
`default_nettype none
// port groups, top to bottom:
// - clock, srst and clk_en; a low clk_en freezes every flop, bus phase included
// - the Avalon-MM slave; an access has one wait cycle, two if it starts in the done cycle, then one answer cycle
// - the frame header from the receiver, which must run on this same clock
//   because no synchroniser stands on the rx_* inputs
// - the filtered header result, one cycle behind the header that produced it
// - the list views; they are combinational from the setup registers
//   and so follow a write at the very next clock edge
// limitation: the list views do not hold over a frame in flight; software must
// change the lists only while the controller is initialising, which the
// protection logic below enforces anyway
module caf_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic rx_extended,
    input wire logic rx_remote,
    input wire logic [28:0] rx_id,
    output logic [28:0] filt_id,
    output logic filt_bypass,
    output caf_pkg::caf_route_e filt_route,
    output logic filt_valid,
    output logic std_list_on,
    output logic [7:0] std_list_count,
    output caf_pkg::caf_addr_t std_list_addr,
    output logic ext_list_on,
    output logic [7:0] ext_list_count,
    output caf_pkg::caf_addr_t ext_list_addr
);
    // all state in one record
    // keeping every flop in one packed struct lets a single always_ff own
    // them all, so reset and clock enable cannot be forgotten for one field
    // the cost is that every field is reset on srst, including the result
    // fields of the frame stage, which do not strictly need it
    typedef struct packed {
        caf_pkg::caf_bus_e phase;        // slave phase
        logic [31:0] rdata;              // registered read data
        logic [1:0] nonmatch_std_action; // standard nonmatch code
        logic [1:0] nonmatch_ext_action; // extended nonmatch code
        logic reject_remote_std;         // drop standard remotes
        logic reject_remote_ext;         // drop extended remotes
        logic [7:0] std_list_size;       // raw standard size
        logic [13:0] std_list_start;     // standard word address
        logic [6:0] ext_list_size;       // raw extended size
        logic [13:0] ext_list_start;     // extended word address
        logic [28:0] ext_id_and_mask;    // extended id mask
        logic init_mode;                 // controller in initialisation
        logic cfg_change;                // configuration change enabled
        logic [28:0] fid;                // masked id out
        logic fbyp;                      // remote drop flag out
        caf_pkg::caf_route_e froute;     // nonmatch route out
        logic fval;                      // filtered frame valid
    } caf_state_s;

    caf_state_s st;
    caf_state_s next_st;
    logic [31:0] wmask;       // byte lanes as a bit mask
    logic [31:0] rd_word;     // read mux result
    logic prot_ok;            // protected writes allowed
    logic [1:0] frame_action; // action for this frame's format
    logic frame_reject;       // reject bit for this frame's format
    caf_pkg::caf_route_e route_w;
    logic bypass_w;
    logic [7:0] std_cnt_w;
    logic [7:0] ext_cnt_w;

    // byte lanes expand to bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
        end
    endgenerate

    // protection gate for the setup registers
    // both control bits must be set; init alone is not enough, so a stray
    // write while the controller is merely stopped leaves the filter intact
    // the control register itself stays writable, otherwise software could
    // never open the gate
    // write to setup fields only in init with change enabled
    assign prot_ok = st.init_mode & st.cfg_change;

    // read path
    // the mux is decoded from the live address in the take cycle and the
    // result is registered, so readdata comes from a flop as required
    // reads are never refused: protected fields read back at any time
    // read mux, reserved bits as zero, unmapped reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            `CAF_OFS_GLOBAL: rd_word = {26'h0, st.nonmatch_std_action, st.nonmatch_ext_action,
                st.reject_remote_std, st.reject_remote_ext};
            `CAF_OFS_STD: rd_word = {8'h00, st.std_list_size, st.std_list_start, 2'b00};
            `CAF_OFS_EXT: rd_word = {9'h000, st.ext_list_size, st.ext_list_start, 2'b00};
            `CAF_OFS_MASK: rd_word = {3'h0, st.ext_id_and_mask};
            `CAF_OFS_CTRL: rd_word = {30'h0, st.cfg_change, st.init_mode};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // per-format choice feeding the router
    // the id format of the current header picks which nonmatch code and which
    // remote-reject bit apply; the two formats never share a setting
    assign frame_action = rx_extended ? st.nonmatch_ext_action : st.nonmatch_std_action;
    assign frame_reject = rx_extended ? st.reject_remote_ext : st.reject_remote_std;

    caf_route u_route (
        .action(frame_action),
        .remote(rx_remote),
        .reject_remote(frame_reject),
        .route(route_w),
        .bypass(bypass_w)
    );

    // standard list view
    caf_limit #(.W(8), .MAX(`CAF_STD_MAX)) u_std (
        .size_raw(st.std_list_size),
        .word_addr(st.std_list_start),
        .size_eff(std_cnt_w),
        .list_on(std_list_on),
        .byte_addr(std_list_addr)
    );

    // extended list view
    caf_limit #(.W(7), .MAX({1'b0, `CAF_EXT_MAX})) u_ext (
        .size_raw(st.ext_list_size),
        .word_addr(st.ext_list_start),
        .size_eff(ext_cnt_w),
        .list_on(ext_list_on),
        .byte_addr(ext_list_addr)
    );

    assign std_list_count = std_cnt_w;
    assign ext_list_count = ext_cnt_w;

    // next state: bus slave, register writes, frame pipeline
    // the bus walks idle, answer, done: the request is taken in idle, the
    // answer cycle drops waitrequest and commits a write, and the done cycle
    // gives the master one edge to release its request before idle looks again
    // without the done cycle a master that releases on the answer edge would
    // be seen as a fresh request and the access would run twice
    // the frame stage samples the setup as it stands when rx_valid is high,
    // so a frame and a setup write in the same cycle see the old setup
    // byte lanes apply per field: lane 0 for the global bits, lane 2 for the
    // list sizes, lanes 0 and 1 for the start addresses
    always_comb begin
        next_st = st;
        next_st.fval = 1'b0;
        // one-cycle registered frame stage
        if (rx_valid) begin
            next_st.fval = 1'b1;
            // standard ids pass unmasked; extended ids are anded
            next_st.fid = rx_extended ? (rx_id & st.ext_id_and_mask) : rx_id;
            next_st.fbyp = bypass_w;
            next_st.froute = route_w;
        end
        unique case (st.phase)
            caf_pkg::CAF_IDLE: begin
                // take the request, answer next cycle
                if (avs_read | avs_write) begin
                    next_st.phase = caf_pkg::CAF_RESP;
                    next_st.rdata = avs_read ? rd_word : 32'h0000_0000;
                end
            end
            caf_pkg::CAF_RESP: begin
                // waitrequest low here; write takes effect at this edge
                next_st.phase = caf_pkg::CAF_DONE;
                if (avs_write) begin
                    if (avs_address == `CAF_OFS_CTRL) begin
                        if (avs_byteenable[0]) begin
                            next_st.init_mode = avs_writedata[`CAF_INIT_BIT];
                            next_st.cfg_change = avs_writedata[`CAF_CCE_BIT];
                        end
                    end else if (prot_ok) begin
                        unique case (avs_address)
                            `CAF_OFS_GLOBAL: begin
                                if (avs_byteenable[0]) begin
                                    next_st.nonmatch_std_action = avs_writedata[`CAF_NFS_HI:`CAF_NFS_LO];
                                    next_st.nonmatch_ext_action = avs_writedata[`CAF_NFE_HI:`CAF_NFE_LO];
                                    next_st.reject_remote_std = avs_writedata[`CAF_RRS_BIT];
                                    next_st.reject_remote_ext = avs_writedata[`CAF_RRE_BIT];
                                end
                            end
                            `CAF_OFS_STD: begin
                                if (avs_byteenable[2]) begin
                                    next_st.std_list_size = avs_writedata[`CAF_LSS_HI:`CAF_LSS_LO];
                                end
                                next_st.std_list_start = (st.std_list_start & ~wmask[`CAF_SA_HI:`CAF_SA_LO])
                                    | (avs_writedata[`CAF_SA_HI:`CAF_SA_LO] & wmask[`CAF_SA_HI:`CAF_SA_LO]);
                            end
                            `CAF_OFS_EXT: begin
                                if (avs_byteenable[2]) begin
                                    next_st.ext_list_size = avs_writedata[`CAF_LSE_HI:`CAF_LSE_LO];
                                end
                                next_st.ext_list_start = (st.ext_list_start & ~wmask[`CAF_SA_HI:`CAF_SA_LO])
                                    | (avs_writedata[`CAF_SA_HI:`CAF_SA_LO] & wmask[`CAF_SA_HI:`CAF_SA_LO]);
                            end
                            `CAF_OFS_MASK: begin
                                next_st.ext_id_and_mask = (st.ext_id_and_mask & ~wmask[`CAF_MASK_HI:0])
                                    | (avs_writedata[`CAF_MASK_HI:0] & wmask[`CAF_MASK_HI:0]);
                            end
                            default: begin
                                // unmapped writes are dropped
                            end
                        endcase
                    end
                end
            end
            caf_pkg::CAF_DONE: begin
                // one idle cycle lets the master drop its request
                next_st.phase = caf_pkg::CAF_IDLE;
            end
            default: next_st.phase = caf_pkg::CAF_IDLE;
        endcase
    end

    // registers, frozen while clock enable is low
    // reset wins over a low clock enable so the block always leaves reset
    // in a known state; the mask resets to all ones, which leaves ids whole
    // init starts set so software may program the lists straight after reset
    // once it has also set the change bit
    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '0;
            st.phase <= caf_pkg::CAF_IDLE;
            st.froute <= caf_pkg::CAF_TO_FIFO0;
            st.ext_id_and_mask <= `CAF_MASK_RESET;
            st.init_mode <= 1'(`CAF_CTRL_RESET);
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // output drive
    // waitrequest comes straight from the phase flop, so it is glitch free
    // and is high through reset, which keeps a master from finishing early
    // every data output below is a flop or a fixed view of flops
    // waitrequest drops only in the answer cycle
    assign avs_waitrequest = (st.phase != caf_pkg::CAF_RESP);
    assign avs_readdata = st.rdata;
    assign filt_id = st.fid;
    assign filt_bypass = st.fbyp;
    assign filt_route = st.froute;
    assign filt_valid = st.fval;
endmodule
`default_nettype wire

// ### sim/caf_top_sva.sv
// caf_top_sva: bus timing and frame result checks at the filter setup block ports
// assumes a bind onto caf_top with clk_en held high by the bench
`timescale 1ns/100ps
`default_nettype none
module caf_top_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic rx_extended,
    input wire logic rx_remote,
    input wire logic [28:0] rx_id,
    input wire logic [28:0] filt_id,
    input wire logic filt_bypass,
    input wire logic filt_valid,
    input wire logic std_list_on,
    input wire logic [7:0] std_list_count,
    input wire caf_pkg::caf_addr_t std_list_addr,
    input wire logic ext_list_on,
    input wire logic [7:0] ext_list_count,
    input wire caf_pkg::caf_addr_t ext_list_addr
);
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_answer; ($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest; endproperty
    property p_short; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_frame; rx_valid |=> filt_valid; endproperty
    // outside a frame nothing moves, so stale results cannot look new
    property p_quiet; !rx_valid |=> !filt_valid && $stable(filt_id); endproperty
    property p_std_id; filt_valid && !$past(rx_extended) |-> filt_id == $past(rx_id); endproperty
    property p_ext_mask; filt_valid && $past(rx_extended) |-> (filt_id & ~$past(rx_id)) == 29'h0; endproperty
    property p_bypass; filt_valid && !$past(rx_remote) |-> !filt_bypass; endproperty
    property p_std_size; std_list_count <= 8'h80 && std_list_on == (std_list_count != 8'h0); endproperty
    property p_ext_size; ext_list_count <= 8'h40 && ext_list_on == (ext_list_count != 8'h0); endproperty
    property p_align; std_list_addr[1:0] == 2'h0 && ext_list_addr[1:0] == 2'h0; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    a_short: assert property (p_short) else $error("answer held too long");
    a_frame: assert property (p_frame) else $error("frame result missing");
    a_quiet: assert property (p_quiet) else $error("result moved between frames");
    a_std_id: assert property (p_std_id) else $error("standard id altered");
    a_ext_mask: assert property (p_ext_mask) else $error("mask set id bits");
    a_bypass: assert property (p_bypass) else $error("data frame rejected");
    a_std_size: assert property (p_std_size) else $error("standard size wrong");
    a_ext_size: assert property (p_ext_size) else $error("extended size wrong");
    a_align: assert property (p_align) else $error("list address unaligned");
    c_ext_remote: cover property (rx_valid && rx_extended && rx_remote);
    c_write: cover property (avs_write && !avs_waitrequest);
    c_std_full: cover property (std_list_count == 8'h80);
endmodule
bind caf_top caf_top_sva i_sva (.clock, .srst, .avs_read, .avs_write, .avs_waitrequest, .rx_valid,
    .rx_extended, .rx_remote, .rx_id, .filt_id, .filt_bypass, .filt_valid, .std_list_on,
    .std_list_count, .std_list_addr, .ext_list_on, .ext_list_count, .ext_list_addr);
`default_nettype wire

// ### sim/caf_node_model.sv
// caf_node_model: a remote node whose received frame headers reach the block
// assumes the block samples a header at the rising edge where rx_valid is high
`timescale 1ns/100ps
`default_nettype none
module caf_node_model (
    input wire logic clock,
    output logic rx_valid,
    output logic rx_extended,
    output logic rx_remote,
    output logic [28:0] rx_id
);
    // idle at time zero
    initial begin
        rx_valid = 1'b0;
        rx_extended = 1'b0;
        rx_remote = 1'b0;
        rx_id = 29'h0;
    end
    // one header for one edge; afterwards the lines carry the inverse, never the old header
    task automatic send(input logic ext, input logic rem, input logic [28:0] id);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_extended <= ext;
        rx_remote <= rem;
        rx_id <= id;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_extended <= ~ext;
        rx_remote <= ~rem;
        rx_id <= ~id;
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// testbench: programs the setup registers over the slave bus and sends frames through the node
// assumes one clock; clk_en stays high and all byte lanes are enabled
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, rx_valid, rx_extended, rx_remote, filt_bypass, filt_valid, std_list_on, ext_list_on;
    logic [28:0] rx_id, filt_id;
    caf_pkg::caf_route_e filt_route;
    logic [7:0] std_list_count, ext_list_count;
    caf_pkg::caf_addr_t std_list_addr, ext_list_addr;
    int error_cnt = 0;
    int total_checks = 0;
    // size table: programmed value and the count it must give
    logic [7:0] sz_s [5] = '{8'h0, 8'h1, 8'h80, 8'h81, 8'hff};
    logic [7:0] cn_s [5] = '{8'h0, 8'h1, 8'h80, 8'h80, 8'h80};
    logic [6:0] sz_e [5] = '{7'h0, 7'h1, 7'h40, 7'h41, 7'h7f};
    logic [7:0] cn_e [5] = '{8'h0, 8'h1, 8'h40, 8'h40, 8'h40};
    always #4 clock = ~clock;
    caf_top i_caf_top (.clock, .srst, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .rx_valid, .rx_extended, .rx_remote, .rx_id,
        .filt_id, .filt_bypass, .filt_route, .filt_valid, .std_list_on, .std_list_count, .std_list_addr,
        .ext_list_on, .ext_list_count, .ext_list_addr);
    caf_node_model i_caf_node_model (.clock, .rx_valid, .rx_extended, .rx_remote, .rx_id);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access: request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) chk("bus answer", 32'h0, 32'h1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk("readback", exp, rd);
    endtask
    // a frame through the node; its result stands one cycle later
    task automatic frame(input logic e, input logic r, input logic [28:0] id, input logic [1:0] code,
                         input logic rej, input logic [28:0] mask);
        i_caf_node_model.send(e, r, id);
        @(posedge clock);
        chk("filt_valid", 32'h1, 32'(filt_valid));
        chk("filt_id", 32'(e ? id & mask : id), 32'(filt_id));
        chk("filt_bypass", 32'(r & rej), 32'(filt_bypass));
        chk("filt_route", code[1] ? 32'(caf_pkg::CAF_DISCARD) : 32'(code), 32'(filt_route));
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        logic [1:0] c;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rd_chk(8'h80, 32'h0);
        rd_chk(8'h90, 32'h1fffffff);
        frame(1'b1, 1'b0, 29'h1abcdef5, 2'h0, 1'b0, 29'h1fffffff);
        // protected writes refused unless both init and change are set
        for (int k = 1; k < 3; k++) begin
            bus(1'b1, 8'h18, 32'(k));
            bus(1'b1, 8'h80, 32'hffffffff);
            rd_chk(8'h80, 32'h0);
        end
        bus(1'b1, 8'h18, 32'h3);
        bus(1'b1, 8'h80, 32'hffffffff);
        rd_chk(8'h80, 32'h3f);
        rd_chk(8'h94, 32'h0);
        // every nonmatch code in both formats, remote reject on and off
        for (int a = 0; a < 4; a++) begin
            c = 2'(a);
            bus(1'b1, 8'h80, {26'h0, c, ~c, c[0], ~c[1]});
            for (int r = 0; r < 2; r++) begin
                frame(1'b0, r[0], 29'h5a5, c, c[0], 29'h1fffffff);
                frame(1'b1, r[0], 29'h15a5a5a5, ~c, ~c[1], 29'h1fffffff);
            end
        end
        bus(1'b1, 8'h90, 32'hf2345678);
        rd_chk(8'h90, 32'h12345678);
        frame(1'b1, 1'b0, 29'h1fffffff, 2'h0, 1'b0, 29'h12345678);
        frame(1'b0, 1'b1, 29'h7ff, 2'h3, 1'b1, 29'h12345678);
        // list sizes at the boundaries, start fields with low bits set
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h84, {8'h0, sz_s[i], 16'h5a5b + 16'(i)});
            bus(1'b1, 8'h88, {9'h0, sz_e[i], 16'ha5a7 - 16'(i)});
            @(posedge clock);
            chk("std count", 32'(cn_s[i]), 32'(std_list_count));
            chk("std on", 32'(i != 0), 32'(std_list_on));
            chk("std addr", 32'((16'h5a5b + 16'(i)) & 16'hfffc), 32'(std_list_addr));
            chk("ext count", 32'(cn_e[i]), 32'(ext_list_count));
            chk("ext on", 32'(i != 0), 32'(ext_list_on));
            chk("ext addr", 32'((16'ha5a7 - 16'(i)) & 16'hfffc), 32'(ext_list_addr));
        end
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h84, 32'h0);
        rd_chk(8'h84, 32'h00ff5a5c);
        give_verdict();
    end
    // watchdog sized well beyond the under two hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
